// ===== design/pwd_pkg.sv
// shared constants and types for the ps/2 wake detector and power-button router
package pwd_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_ROUTE_SRC = 10'h01b;
   localparam logic [9:0] IDX_ROUTE_GEN = 10'h01c;
   localparam logic [9:0] IDX_CTRL = 10'h020;
   localparam logic [9:0] IDX_KEY0 = 10'h028;
   localparam logic [9:0] IDX_STATUS = 10'h030;
   localparam int ADDR_LSB = 2;
   localparam int KEY_SEL_LSB = 3;
   localparam int N_KEYS = 8;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // source routing bits
   localparam int SRC_RI1 = 0;
   localparam int SRC_RI2 = 1;
   localparam int SRC_KBD = 2;
   localparam int SRC_MOUSE = 3;
   localparam int SRC_IR = 4;
   localparam logic [7:0] SRC_MASK = 8'h1f;
   // control register fields
   localparam int CTRL_PAR_DIS = 7;
   localparam int MOUSE_HI = 6;
   localparam int MOUSE_LO = 4;
   localparam int KBD_HI = 3;
   localparam int KBD_LO = 0;
   localparam logic [3:0] KBD_OFF = 4'h0;
   localparam logic [3:0] KBD_PW_OFFSET = 4'h7;
   localparam logic [3:0] KBD_SEQ_OFFSET = 4'h1;
   // keyboard bytes
   localparam logic [7:0] KEY_IGNORE = 8'h00;
   localparam logic [7:0] BREAK_PREFIX = 8'hf0;
   localparam logic [7:0] EXT_PREFIX = 8'he0;
   // mouse packet first byte
   localparam int BTN_LEFT = 0;
   localparam int BTN_MID = 2;
   localparam int PKT_SYNC = 3;
   localparam logic [2:0] SEL_LEFT = 3'h1;
   localparam logic [2:0] SEL_RIGHT = 3'h2;
   localparam logic [2:0] SEL_ANY = 3'h7;
   // double-click window
   localparam int CLK_HZ = 125_000_000;
   localparam int DCLICK_MS = 500;
   localparam int DCLICK_CYCLES = DCLICK_MS * (CLK_HZ / 1000);
   localparam int TMR_W = 27;
   localparam int RX_BITS = 8;

   typedef enum logic [2:0] {
      MS_OFF = 3'h0,
      MS_ANY = 3'h1,
      MS_LEFT = 3'h2,
      MS_LEFT_DBL = 3'h3,
      MS_RIGHT = 3'h4,
      MS_RIGHT_DBL = 3'h5,
      MS_RSVD = 3'h6,
      MS_ANY_DBL = 3'h7
   } pwd_mouse_mode_t;

   // receive frame states, gray coded
   typedef enum logic [1:0] {
      RX_START = 2'b00,
      RX_DATA = 2'b01,
      RX_PAR = 2'b11,
      RX_STOP = 2'b10
   } pwd_rx_state_t;

   typedef struct packed {
      logic valid;
      logic parity_ok;
      logic [7:0] data;
   } pwd_rx_byte_t;

   typedef struct packed {
      logic ir;
      logic ri2;
      logic ri1;
      logic [7:0] gen;
   } pwd_raw_events_t;
endpackage

// ===== design/pwd_ps2_rx.sv
// passive ps/2 receiver: samples clock and data pins, frames one byte
`timescale 1ns/10ps
module pwd_ps2_rx (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic enable, // receive only while detection is on
   input wire logic ps2_clk_in, // ps/2 clock pin
   input wire logic ps2_data_in, // ps/2 data pin
   output pwd_pkg::pwd_rx_byte_t rx_byte // received byte, valid one cycle
);
   logic [1:0] clk_meta_q;
   logic [1:0] dat_meta_q;
   logic clk_prev_q;
   logic fall;
   pwd_pkg::pwd_rx_state_t state_q;
   logic [2:0] cnt_q;
   logic [7:0] shift_q;
   logic par_q;

   // two-stage synchronisers; bit 0 is read only by bit 1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_meta_q <= 2'b11;
         dat_meta_q <= 2'b11;
         clk_prev_q <= 1'b1;
      end else begin
         clk_meta_q <= {clk_meta_q[0], ps2_clk_in};
         dat_meta_q <= {dat_meta_q[0], ps2_data_in};
         clk_prev_q <= clk_meta_q[1];
      end
   end

   // device drives data, host samples on falling clock
   assign fall = clk_prev_q & ~clk_meta_q[1];

   // frame: start, eight data bits lsb first, odd parity, stop
   // no frame timeout: a glitch desyncs until the next idle start bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= pwd_pkg::RX_START;
         cnt_q <= 3'h0;
         shift_q <= pwd_pkg::RST_BYTE;
         par_q <= 1'b0;
         rx_byte <= '0;
      end else begin
         rx_byte.valid <= 1'b0;
         if (!enable) begin
            state_q <= pwd_pkg::RX_START;
         end else if (fall) begin
            unique case (state_q)
               pwd_pkg::RX_START: begin
                  cnt_q <= 3'h0;
                  if (!dat_meta_q[1]) begin
                     state_q <= pwd_pkg::RX_DATA;
                  end
               end
               pwd_pkg::RX_DATA: begin
                  shift_q <= {dat_meta_q[1], shift_q[7:1]};
                  cnt_q <= cnt_q + 3'h1;
                  if (cnt_q == 3'(pwd_pkg::RX_BITS - 1)) begin
                     state_q <= pwd_pkg::RX_PAR;
                  end
               end
               pwd_pkg::RX_PAR: begin
                  par_q <= dat_meta_q[1];
                  state_q <= pwd_pkg::RX_STOP;
               end
               pwd_pkg::RX_STOP: begin
                  state_q <= pwd_pkg::RX_START;
                  rx_byte.valid <= dat_meta_q[1];
                  rx_byte.parity_ok <= ^{shift_q, par_q};
                  rx_byte.data <= shift_q;
               end
            endcase
         end
      end
   end
endmodule

// ===== design/pwd_mouse_detect.sv
// mouse packet tracker and click, double-click and movement detection
`timescale 1ns/10ps
module pwd_mouse_detect #(
   parameter int DCLICK_CYCLES = pwd_pkg::DCLICK_CYCLES // double-click window
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input pwd_pkg::pwd_mouse_mode_t mode, // selected wake condition
   input wire logic byte_ok, // accepted byte strobe
   input wire logic [7:0] byte_data, // accepted byte value
   output logic wake // one-cycle wake pulse
);
   logic [1:0] pos_q;
   logic [2:0] btn_q;
   logic [2:0] prev_btn_q;
   logic move_q;
   logic armed_q;
   logic [pwd_pkg::TMR_W-1:0] tmr_q;
   logic pkt_end;
   logic [2:0] sel;
   logic click;
   logic dbl;

   // last byte of a three-byte packet
   assign pkt_end = byte_ok && pos_q == 2'h2;

   // button mask of the selected mode
   always_comb begin
      unique case (mode)
         pwd_pkg::MS_LEFT, pwd_pkg::MS_LEFT_DBL: sel = pwd_pkg::SEL_LEFT;
         pwd_pkg::MS_RIGHT, pwd_pkg::MS_RIGHT_DBL: sel = pwd_pkg::SEL_RIGHT;
         pwd_pkg::MS_ANY_DBL: sel = pwd_pkg::SEL_ANY;
         default: sel = 3'h0;
      endcase
   end

   // a click is a button going down between packets
   assign click = pkt_end & |(btn_q & ~prev_btn_q & sel);
   assign dbl = mode == pwd_pkg::MS_LEFT_DBL || mode == pwd_pkg::MS_RIGHT_DBL
      || mode == pwd_pkg::MS_ANY_DBL;

   // packet position; resync on a first byte without its sync bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_q <= 2'h0;
         btn_q <= 3'h0;
         prev_btn_q <= 3'h0;
         move_q <= 1'b0;
      end else if (mode == pwd_pkg::MS_OFF) begin
         pos_q <= 2'h0;
         prev_btn_q <= 3'h0;
      end else if (byte_ok) begin
         unique case (pos_q)
            2'h0: begin
               if (byte_data[pwd_pkg::PKT_SYNC]) begin
                  btn_q <= byte_data[pwd_pkg::BTN_MID:pwd_pkg::BTN_LEFT];
                  pos_q <= 2'h1;
               end
            end
            2'h1: begin
               move_q <= byte_data != pwd_pkg::RST_BYTE;
               pos_q <= 2'h2;
            end
            default: begin
               prev_btn_q <= btn_q;
               pos_q <= 2'h0;
            end
         endcase
      end
   end

   // double-click window: first click arms, second inside window wakes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b0;
         tmr_q <= '0;
         wake <= 1'b0;
      end else begin
         wake <= 1'b0;
         if (tmr_q != '0) begin
            tmr_q <= tmr_q - 1'b1;
         end else begin
            armed_q <= 1'b0;
         end
         if (mode == pwd_pkg::MS_ANY) begin
            wake <= pkt_end & (|btn_q | move_q | byte_data != pwd_pkg::RST_BYTE);
         end else if (click && !dbl) begin
            wake <= 1'b1;
         end else if (click && armed_q) begin
            wake <= 1'b1;
            armed_q <= 1'b0;
            tmr_q <= '0;
         end else if (click) begin
            armed_q <= 1'b1;
            tmr_q <= pwd_pkg::TMR_W'(DCLICK_CYCLES);
         end
      end
   end
endmodule

// ===== design/pwd_wake_route.sv
// ps/2 wake-up detection and power-button routing, apb register slave
`timescale 1ns/10ps
// Notes on behaviour
// - source routing register clears to zero and gates events to power button
// - source bits: 4 infrared, 3 mouse, 2 keyboard, 1 ring two, 0 ring one
// - routing bit one passes its event, zero blocks it
// - general routing register clears to zero, bit n gates general input n
// - keyboard and mouse detectors run independently at the same time
// - detection is own hardware, needs no keyboard controller
// - keyboard: any key, password of 1-8 keys, raw sequence of 2-8 bytes
// - password mode drops extended and break prefixes, compares scan codes only
// - sequence mode compares every received byte, prefixes included
// - mouse field selects movement, click or double-click detection
// - a key byte of zero accepts any byte in that position
// - mouse field codes as listed; six treated as disabled
// - keyboard field zero disables keyboard detection
module pwd_wake_route #(
   parameter int DCLICK_CYCLES = pwd_pkg::DCLICK_CYCLES // double-click window
) (
   input wire logic pclk, // system clock, 125 mhz
   input wire logic presetn, // async reset, active low
   input wire logic [11:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic kbd_clk_in, // keyboard clock pin
   input wire logic kbd_data_in, // keyboard data pin
   input wire logic mouse_clk_in, // mouse clock pin
   input wire logic mouse_data_in, // mouse data pin
   input wire logic consumer_infrared_event, // raw infrared event
   input wire logic ring_indicate_one_event, // raw ring one event
   input wire logic ring_indicate_two_event, // raw ring two event
   input wire logic [7:0] general_input_event, // raw general input events
   output logic keyboard_event, // keyboard match pulse
   output logic mouse_event, // mouse match pulse
   output logic pbtn_wake_request // request to power-button pulse generator
);
   logic [9:0] idx;
   logic wr;
   logic setup;
   logic [7:0] route_src_q;
   logic [7:0] route_gen_q;
   logic [7:0] ctrl_q;
   logic [7:0] key_q [pwd_pkg::N_KEYS];
   logic [7:0] kbd_last_q;
   logic [7:0] mouse_last_q;
   logic err_q;
   pwd_pkg::pwd_raw_events_t raw_meta_q;
   pwd_pkg::pwd_raw_events_t raw_q;
   pwd_pkg::pwd_rx_byte_t kbd_rx;
   pwd_pkg::pwd_rx_byte_t mouse_rx;
   pwd_pkg::pwd_mouse_mode_t mouse_mode;
   logic [3:0] kfield;
   logic par_dis;
   logic pw_mode;
   logic [3:0] target;
   logic kbd_ok;
   logic mouse_ok;
   logic skip_q;
   logic drop;
   logic cmp;
   logic [2:0] kidx_q;
   logic hit;
   logic restart;
   logic last;
   logic [7:0] sources;
   logic [31:0] rd_d;

   // address decode, shared by write and read paths
   function automatic logic is_key(input logic [9:0] a);
      return a[9:pwd_pkg::KEY_SEL_LSB] == pwd_pkg::IDX_KEY0[9:pwd_pkg::KEY_SEL_LSB];
   endfunction

   function automatic logic is_mapped(input logic [9:0] a);
      return a == pwd_pkg::IDX_ROUTE_SRC || a == pwd_pkg::IDX_ROUTE_GEN
         || a == pwd_pkg::IDX_CTRL || a == pwd_pkg::IDX_STATUS || is_key(a);
   endfunction

   // key byte comparison; zero means accept anything
   function automatic logic key_hit(input logic [7:0] key, input logic [7:0] data);
      return key == pwd_pkg::KEY_IGNORE || key == data;
   endfunction

   assign idx = paddr[11:pwd_pkg::ADDR_LSB];
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   // zero-wait slave: read data latched in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & err_q;

   // control register fields
   assign kfield = ctrl_q[pwd_pkg::KBD_HI:pwd_pkg::KBD_LO];
   assign par_dis = ctrl_q[pwd_pkg::CTRL_PAR_DIS];
   assign mouse_mode = pwd_pkg::pwd_mouse_mode_t'(ctrl_q[pwd_pkg::MOUSE_HI:pwd_pkg::MOUSE_LO]);

   // routing and control registers, all zero after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_src_q <= pwd_pkg::RST_BYTE;
         route_gen_q <= pwd_pkg::RST_BYTE;
         ctrl_q <= pwd_pkg::RST_BYTE;
      end else if (wr) begin
         if (idx == pwd_pkg::IDX_ROUTE_SRC) begin
            route_src_q <= pwdata[7:0] & pwd_pkg::SRC_MASK;
         end
         if (idx == pwd_pkg::IDX_ROUTE_GEN) begin
            route_gen_q <= pwdata[7:0];
         end
         if (idx == pwd_pkg::IDX_CTRL) begin
            ctrl_q <= pwdata[7:0];
         end
      end
   end

   // key match bytes, indexed by the low address bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < pwd_pkg::N_KEYS; i++) begin
            key_q[i] <= pwd_pkg::RST_BYTE;
         end
      end else if (wr && is_key(idx)) begin
         key_q[idx[pwd_pkg::KEY_SEL_LSB-1:0]] <= pwdata[7:0];
      end
   end

   // read mux
   always_comb begin
      rd_d = pwd_pkg::RST_WORD;
      if (idx == pwd_pkg::IDX_ROUTE_SRC) begin
         rd_d[7:0] = route_src_q;
      end else if (idx == pwd_pkg::IDX_ROUTE_GEN) begin
         rd_d[7:0] = route_gen_q;
      end else if (idx == pwd_pkg::IDX_CTRL) begin
         rd_d[7:0] = ctrl_q;
      end else if (is_key(idx)) begin
         rd_d[7:0] = key_q[idx[pwd_pkg::KEY_SEL_LSB-1:0]];
      end else if (idx == pwd_pkg::IDX_STATUS) begin
         rd_d = {13'h0000, kidx_q, mouse_last_q, kbd_last_q};
      end
   end

   // read data and error flag taken at the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= pwd_pkg::RST_WORD;
         err_q <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? pwd_pkg::RST_WORD : rd_d;
         err_q <= !is_mapped(idx);
      end
   end

   // two receivers, each with its own pins and framing state
   pwd_ps2_rx u_kbd_rx (
      .pclk(pclk),
      .presetn(presetn),
      .enable(kfield != pwd_pkg::KBD_OFF),
      .ps2_clk_in(kbd_clk_in),
      .ps2_data_in(kbd_data_in),
      .rx_byte(kbd_rx)
   );

   pwd_ps2_rx u_mouse_rx (
      .pclk(pclk),
      .presetn(presetn),
      .enable(mouse_mode != pwd_pkg::MS_OFF),
      .ps2_clk_in(mouse_clk_in),
      .ps2_data_in(mouse_data_in),
      .rx_byte(mouse_rx)
   );

   // parity errors drop the byte unless checking is disabled
   assign kbd_ok = kbd_rx.valid & (kbd_rx.parity_ok | par_dis);
   assign mouse_ok = mouse_rx.valid & (mouse_rx.parity_ok | par_dis);

   // last received bytes, captured only while detection is on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kbd_last_q <= pwd_pkg::RST_BYTE;
         mouse_last_q <= pwd_pkg::RST_BYTE;
      end else begin
         if (kbd_ok) begin
            kbd_last_q <= kbd_rx.data;
         end
         if (mouse_ok) begin
            mouse_last_q <= mouse_rx.data;
         end
      end
   end

   // keyboard mode: field 8-15 password, 1-7 raw sequence
   assign pw_mode = kfield[3];
   assign target = pw_mode ? kfield - pwd_pkg::KBD_PW_OFFSET
      : kfield + pwd_pkg::KBD_SEQ_OFFSET;

   // password mode drops prefixes and the released key after a break
   assign drop = pw_mode & (kbd_rx.data == pwd_pkg::BREAK_PREFIX
      | kbd_rx.data == pwd_pkg::EXT_PREFIX | skip_q);
   // sequence mode compares every byte, prefixes included
   assign cmp = kbd_ok & ~drop;
   assign hit = key_hit(key_q[kidx_q], kbd_rx.data);
   assign restart = key_hit(key_q[0], kbd_rx.data);
   assign last = {1'b0, kidx_q} + 4'h1 == target;

   // break-follower skip flag, password mode only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_q <= 1'b0;
      end else if (!pw_mode) begin
         skip_q <= 1'b0;
      end else if (kbd_ok) begin
         if (kbd_rx.data == pwd_pkg::BREAK_PREFIX) begin
            skip_q <= 1'b1;
         end else if (kbd_rx.data != pwd_pkg::EXT_PREFIX) begin
            skip_q <= 1'b0;
         end
      end
   end

   // match position; a mismatch retries the byte as a first key
   // so a partly typed password followed by the real one still wakes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kidx_q <= 3'h0;
         keyboard_event <= 1'b0;
      end else begin
         keyboard_event <= 1'b0;
         if (kfield == pwd_pkg::KBD_OFF || (wr && idx == pwd_pkg::IDX_CTRL)) begin
            kidx_q <= 3'h0;
         end else if (cmp) begin
            if (hit && last) begin
               kidx_q <= 3'h0;
               keyboard_event <= 1'b1;
            end else if (hit) begin
               kidx_q <= kidx_q + 3'h1;
            end else if (restart && target == 4'h1) begin
               kidx_q <= 3'h0;
               keyboard_event <= 1'b1;
            end else begin
               kidx_q <= restart ? 3'h1 : 3'h0;
            end
         end
      end
   end

   pwd_mouse_detect #(
      .DCLICK_CYCLES(DCLICK_CYCLES)
   ) u_mouse (
      .pclk(pclk),
      .presetn(presetn),
      .mode(mouse_mode),
      .byte_ok(mouse_ok),
      .byte_data(mouse_rx.data),
      .wake(mouse_event)
   );

   // raw pin events pass two flip-flops before routing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_meta_q <= '0;
         raw_q <= '0;
      end else begin
         raw_meta_q <= {consumer_infrared_event, ring_indicate_two_event,
            ring_indicate_one_event, general_input_event};
         raw_q <= raw_meta_q;
      end
   end

   // source vector in register bit order
   always_comb begin
      sources = pwd_pkg::RST_BYTE;
      sources[pwd_pkg::SRC_IR] = raw_q.ir;
      sources[pwd_pkg::SRC_MOUSE] = mouse_event;
      sources[pwd_pkg::SRC_KBD] = keyboard_event;
      sources[pwd_pkg::SRC_RI2] = raw_q.ri2;
      sources[pwd_pkg::SRC_RI1] = raw_q.ri1;
   end

   // gated events toward the power button, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pbtn_wake_request <= 1'b0;
      end else begin
         pbtn_wake_request <= |(sources & route_src_q)
            | |(raw_q.gen & route_gen_q);
      end
   end
endmodule

// ===== bench/pwd_wake_route_monitor.sv
// concurrent checks on the wake router's register and routing ports
`timescale 1ns/10ps
module pwd_wake_route_monitor #(
   parameter int DCLICK_CYCLES = pwd_pkg::DCLICK_CYCLES // double-click window
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic [11:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic consumer_infrared_event, // raw infrared event
   input wire logic [7:0] general_input_event, // raw general events
   input wire logic keyboard_event, // keyboard match pulse
   input wire logic mouse_event, // mouse match pulse
   input wire logic pbtn_wake_request // power-button request
);
   logic [7:0] src_q, gen_q, ctl_q;
   logic wr_en, rd_en, en_any;
   logic [9:0] idx;
   assign idx = paddr[11:2];
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_en = psel && penable && pready && !pwrite;
   assign en_any = |{src_q, gen_q};
   // shadow registers, so routing checks need no view of the body
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= 8'h00;
         gen_q <= 8'h00;
         ctl_q <= 8'h00;
      end else if (wr_en) begin
         if (idx == pwd_pkg::IDX_ROUTE_SRC) src_q <= pwdata[7:0] & pwd_pkg::SRC_MASK;
         if (idx == pwd_pkg::IDX_ROUTE_GEN) gen_q <= pwdata[7:0];
         if (idx == pwd_pkg::IDX_CTRL) ctl_q <= pwdata[7:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_src_rd; rd_en && idx == pwd_pkg::IDX_ROUTE_SRC |-> prdata == {24'h00_0000, src_q}; endproperty
   a_src_rd: assert property (p_src_rd) else $error("source routing readback wrong");
   property p_gen_rd; rd_en && idx == pwd_pkg::IDX_ROUTE_GEN |-> prdata == {24'h00_0000, gen_q}; endproperty
   a_gen_rd: assert property (p_gen_rd) else $error("general routing readback wrong");
   property p_pbtn_en; pbtn_wake_request |-> $past(en_any); endproperty
   a_pbtn_en: assert property (p_pbtn_en) else $error("request with no routing enabled");
   property p_ir; (consumer_infrared_event && src_q[4]) [*4] |=> pbtn_wake_request; endproperty
   a_ir: assert property (p_ir) else $error("infrared event not routed");
   property p_gen; ((general_input_event & gen_q) != 8'h00) [*4] |=> pbtn_wake_request; endproperty
   a_gen: assert property (p_gen) else $error("general event not routed");
   property p_key_rt; keyboard_event && src_q[2] |=> pbtn_wake_request; endproperty
   a_key_rt: assert property (p_key_rt) else $error("keyboard match not routed");
   property p_ms_rt; mouse_event && src_q[3] |=> pbtn_wake_request; endproperty
   a_ms_rt: assert property (p_ms_rt) else $error("mouse match not routed");
   property p_key_off; keyboard_event |-> ctl_q[3:0] != 4'h0; endproperty
   a_key_off: assert property (p_key_off) else $error("keyboard match while off");
   property p_ms_off; mouse_event |-> ctl_q[6:4] != 3'h0 && ctl_q[6:4] != 3'h6; endproperty
   a_ms_off: assert property (p_ms_off) else $error("mouse match while off");
endmodule
bind pwd_wake_route pwd_wake_route_monitor #(.DCLICK_CYCLES(DCLICK_CYCLES)) u_mon (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .consumer_infrared_event(consumer_infrared_event), .general_input_event(general_input_event),
   .keyboard_event(keyboard_event), .mouse_event(mouse_event),
   .pbtn_wake_request(pbtn_wake_request));

// ===== bench/pwd_ps2_dev.sv
// ps/2 device model: sends frames on a clock and data pair
`timescale 1ns/10ps
module pwd_ps2_dev (
   output logic clk_o, // link clock, stands high between frames
   output logic dat_o // link data, pulled high when released
);
   initial begin
      clk_o = 1'b1;
      dat_o = 1'b1;
   end
   // start, eight bits lsb first, odd parity, stop; 64 ns clock
   task automatic send(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ~^b, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         dat_o = f[i];
         #16 clk_o = 1'b0;
         #32 clk_o = 1'b1;
         #16;
      end
      dat_o = 1'b1;
      #200;
   endtask
endmodule

// ===== bench/pwd_wake_route_tb_top.sv
// self-checking bench for the wake detector and power-button router
`timescale 1ns/10ps
module pwd_wake_route_tb_top;
   localparam int DCLK = 2000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic key_clk, key_dat, ms_clk, ms_dat, key_ev, ms_ev, pbtn;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   pwd_pkg::pwd_raw_events_t raw;
   logic [32:0] exq[$];
   int mismatches, n_checks, n_key, n_ms, e_key, e_ms, cyc, seed;
   pwd_wake_route #(.DCLICK_CYCLES(DCLK)) u_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .kbd_clk_in(key_clk), .kbd_data_in(key_dat), .mouse_clk_in(ms_clk),
      .mouse_data_in(ms_dat), .consumer_infrared_event(raw.ir),
      .ring_indicate_one_event(raw.ri1), .ring_indicate_two_event(raw.ri2),
      .general_input_event(raw.gen), .keyboard_event(key_ev), .mouse_event(ms_ev),
      .pbtn_wake_request(pbtn));
   pwd_ps2_dev u_keys (.clk_o(key_clk), .dat_o(key_dat));
   pwd_ps2_dev u_mouse (.clk_o(ms_clk), .dat_o(ms_dat));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // reads note {error, data} at setup, so the watcher never races the note
   task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] d,
                      input logic [32:0] e);
      @(posedge pclk);
      if (!wr) exq.push_back(e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // field cleared first, keys in order, then the new field value
   task automatic keys(input logic [7:0] c, input logic [23:0] k);
      apb(pwd_pkg::IDX_CTRL, 1, 8'h00, 0);
      for (int n = 0; n < 3; n++) apb(pwd_pkg::IDX_KEY0 + 10'(n), 1, k[n*8+:8], 0);
      apb(pwd_pkg::IDX_CTRL, 1, c, 0);
   endtask
   task automatic kseq(input logic [31:0] b, input int n);
      for (int j = 0; j < n; j++) u_keys.send(b[j*8+:8]);
   endtask
   task automatic pkt(input logic [7:0] b0);
      u_mouse.send(b0);
      u_mouse.send(8'h00);
      u_mouse.send(8'h00);
   endtask
   // one raw source: blocked while its enable is clear, passed once set
   task automatic route(input int i);
      logic [10:0] m;
      m = 11'h001 << i;
      @(posedge pclk);
      raw <= m;
      repeat (6) @(posedge pclk);
      chk(pbtn, 0);
      apb(pwd_pkg::IDX_ROUTE_GEN, 1, m[7:0], 0);
      apb(pwd_pkg::IDX_ROUTE_SRC, 1, {3'h0, m[10], 2'h0, m[9:8]}, 0);
      repeat (2) @(posedge pclk);
      chk(pbtn, 1);
      apb(pwd_pkg::IDX_ROUTE_GEN, 1, 8'h00, 0);
      apb(pwd_pkg::IDX_ROUTE_SRC, 1, 8'h00, 0);
      raw <= 11'h000;
   endtask
   // watcher: read answers against the oldest note, match pulses, hang limit
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exq.pop_front());
      if (key_ev === 1'b1) n_key++;
      if (ms_ev === 1'b1) n_ms++;
      if (cyc == 90000) begin
         mismatches++;
         final_report();
      end
   end
   initial begin
      logic [7:0] v, b;
      {presetn, psel, penable, pwrite, paddr, pwdata, raw, cyc, seed} = '0;
      seed = 2;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(pwd_pkg::IDX_ROUTE_SRC, 0, 0, 0);
      apb(pwd_pkg::IDX_ROUTE_GEN, 0, 0, 0);
      apb(10'h3ff, 0, 0, {1'b1, 32'h0000_0000});
      apb(pwd_pkg::IDX_ROUTE_SRC, 1, 8'hff, 0);
      apb(pwd_pkg::IDX_ROUTE_SRC, 0, 0, 33'h0_0000_001f);
      for (int i = 0; i < 11; i++) route(i);
      v = 8'($random(seed));
      apb(pwd_pkg::IDX_ROUTE_GEN, 1, v, 0);
      apb(pwd_pkg::IDX_ROUTE_GEN, 0, 0, {25'h000_0000, v});
      apb(pwd_pkg::IDX_ROUTE_SRC, 1, 8'h0c, 0);
      // any key: zero keys take whatever bytes arrive
      keys(8'h01, 24'h00_0000);
      kseq(32'($random(seed)), 2);
      e_key++;
      chk(n_key, e_key);
      keys(8'h09, 24'h00_321c);
      kseq(32'h321c_f01c, 4);
      e_key++;
      chk(n_key, e_key);
      keys(8'h02, 24'h1c_f0e0);
      kseq(32'h001c_f0e0, 3);
      e_key++;
      chk(n_key, e_key);
      keys(8'h00, 24'h00_0000);
      kseq(32'h0000_1c1c, 2);
      chk(n_key, e_key);
      keys(8'h11, 24'h00_0000);
      fork
         kseq(32'h0000_2a2a, 2);
         pkt(8'h09);
      join
      e_key++;
      e_ms++;
      chk(n_key, e_key);
      chk(n_ms, e_ms);
      // every mouse mode: release, press, release, press
      for (int m = 0; m < 8; m++) begin
         repeat (DCLK + 100) @(posedge pclk);
         keys({1'b0, m[2:0], 4'h0}, 24'h00_0000);
         b = (m == 4 || m == 5) ? 8'h0a : 8'h09;
         repeat (2) begin
            pkt(8'h08);
            pkt(b);
         end
         e_ms += (m == 0 || m == 6) ? 0 : ((m[0] && m != 1) ? 1 : 2);
         chk(n_ms, e_ms);
      end
      final_report();
   end
endmodule
